// ---- bench/pfe_ctm_model.sv ----
// master time message sender and count clock source
`timescale 1ns/1ps
module pfe_ctm_model
	import pfe_pkg::*;
(
	input  wire logic      clk,
	input  wire logic      rstn,
	input  wire logic      run,
	input  wire logic      req,
	input  wire logic      part,
	input  wire pfe_msg_t  req_msg,
	output logic           count_clk,
	output logic           msg_start,
	output logic           msg_done,
	output pfe_msg_t       msg
);
	logic [1:0] div;
	logic [1:0] cnt;
	pfe_msg_t   hold;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			div <= '0;
			cnt <= '0;
			hold <= '0;
			count_clk <= 1'b0;
			msg_start <= 1'b0;
			msg_done <= 1'b0;
			msg <= '0;
		end else begin
			// count clock stands still while not running
			div <= run ? div + 2'h1 : 2'h0;
			count_clk <= run & div[1];
			// partial frame: done without start
			msg_start <= req & ~part;
			if (req) begin
				cnt <= 2'h1;
				hold <= req_msg;
			end else if (cnt != 2'h0) begin
				cnt <= cnt + 2'h1;
			end
			msg_done <= cnt == 2'h3;
			// bus shows a changing pattern outside done
			msg <= (cnt == 2'h3) ? hold : ~msg;
		end
	end
endmodule

// ---- bench/pfe_monitor.sv ----
// assertion checker bound to the facility enable top
`timescale 1ns/1ps
module pfe_monitor
	import pfe_pkg::*;
(
	input wire logic              clk,
	input wire logic              rstn,
	input wire logic              master_mode,
	input wire logic              alarm_wr,
	input wire logic [TIME_W-1:0] alarm_time,
	input wire logic              count_clk_in,
	input wire logic              count_strobe_out,
	input wire logic [TIME_W-1:0] elapsed_time,
	input wire logic              time_valid,
	input wire logic              alarm_pending,
	input wire logic              alarm_out,
	input wire logic              pulse_out,
	input wire logic              phase_flag,
	input wire logic              wave_out,
	input wire logic              wave_bit,
	input wire logic [1:0]        sync_count
);
	// ------------------------------------------------------------------
	// last written alarm time
	// ------------------------------------------------------------------
	logic [TIME_W-1:0] alm_q;
	logic [TIME_W-1:0] next_alm_q;
	always_comb begin
		next_alm_q = alarm_wr ? alarm_time : alm_q;
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			alm_q <= '0;
		end else begin
			alm_q <= next_alm_q;
		end
	end
	// ------------------------------------------------------------------
	// properties
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_early;
		master_mode && sync_count != 2'h2;
	endsequence
	property p_strobe; count_strobe_out == count_clk_in; endproperty
	a_strobe: assert property (p_strobe)
		else $error("count strobe differs from count clock");
	property p_mirror; wave_bit == wave_out; endproperty
	a_mirror: assert property (p_mirror)
		else $error("wave bit differs from wave output");
	property p_gate; s_early |-> !(alarm_out || pulse_out || wave_out); endproperty
	a_gate: assert property (p_gate)
		else $error("facility output before second sync");
	property p_pend; s_early |-> alarm_pending; endproperty
	a_pend: assert property (p_pend)
		else $error("alarm pending cleared early");
	property p_valid; s_early |-> !time_valid; endproperty
	a_valid: assert property (p_valid)
		else $error("time valid before second sync");
	property p_sa_valid; !master_mode |=> time_valid; endproperty
	a_sa_valid: assert property (p_sa_valid)
		else $error("time valid low in stand-alone");
	property p_phase; $changed(phase_flag) |-> sync_count == 2'h2; endproperty
	a_phase: assert property (p_phase)
		else $error("phase flag changed before second sync");
	property p_sat; sync_count == 2'h2 |=> sync_count == 2'h2; endproperty
	a_sat: assert property (p_sat)
		else $error("sync count left saturation");
	property p_alarm; alarm_out |-> elapsed_time == alm_q && !alarm_pending; endproperty
	a_alarm: assert property (p_alarm)
		else $error("alarm off its programmed time");
endmodule

// ---- bench/pfe_top_test.sv ----
// self-checking bench for the facility enable block
`timescale 1ns/1ps
module pfe_top_test
	import pfe_pkg::*;
;
	logic clk, rstn, master_mode, run, req, part, msg_start, msg_done, count_clk_in;
	logic alarm_wr, pulse_par_wr, wave_par_wr, phase_ref_in, count_strobe_out;
	logic time_valid, alarm_pending, alarm_out, pulse_out, phase_flag, wave_out, wave_bit;
	pfe_msg_t          req_msg, msg;
	pfe_pulse_par_t    pulse_par;
	pfe_wave_par_t     wave_par;
	logic [TIME_W-1:0] alarm_time, elapsed_time;
	logic [MONO_W-1:0] mono_time;
	logic [1:0]        sync_count;
	int                bad_count, cmp_count;

	pfe_ctm_model ctm_u (.clk, .rstn, .run, .req, .part, .req_msg,
		.count_clk(count_clk_in), .msg_start, .msg_done, .msg);
	pfe_top dut_u (.clk, .rstn, .master_mode, .msg_start, .msg_done, .msg, .alarm_wr,
		.alarm_time, .pulse_par_wr, .pulse_par, .wave_par_wr, .wave_par, .count_clk_in,
		.phase_ref_in, .count_strobe_out, .elapsed_time, .mono_time, .time_valid,
		.alarm_pending, .alarm_out, .pulse_out, .phase_flag, .wave_out, .wave_bit,
		.sync_count);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ------------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wrap_up;
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic rst(input logic mode);
		rstn = 1'b0;
		run = 1'b0;
		master_mode = mode;
		cyc(10);
		rstn = 1'b1;
		cyc(1);
	endtask
	task automatic send(input logic [31:0] tm, input logic p, input logic ok, input logic pr);
		req_msg = '0;
		req_msg.elapsed = tm;
		req_msg.pulse = p;
		req_msg.pulse_par_ok = ok;
		req_msg.pulse_par = {24'h000010, 24'h000004};
		req_msg.wave_par_ok = ok;
		req_msg.wave_par = 16'h0003;
		part = pr;
		req = 1'b1;
		cyc(1);
		req = 1'b0;
		cyc(6);
	endtask
	task automatic hunt(input int sel);
		for (int i = 0; i < 400; i++) begin
			cyc(1);
			if (sel == 0 && alarm_out === 1'b1) break;
			if (sel == 1 && pulse_out === 1'b1) break;
			if (sel == 2 && pulse_out === 1'b0) break;
			if (sel == 3 && wave_out === 1'b1) break;
			if (sel == 4 && wave_out === 1'b0) break;
		end
	endtask
	task automatic wr_alarm(input logic [31:0] t);
		alarm_time = t;
		alarm_wr = 1'b1;
		cyc(1);
		alarm_wr = 1'b0;
	endtask
	// ------------------------------------------------------------------
	// tests
	// ------------------------------------------------------------------
	initial begin
		{rstn, run, req, part, alarm_wr, pulse_par_wr, wave_par_wr, phase_ref_in} = '0;
		{master_mode, req_msg, alarm_time, pulse_par, wave_par} = '0;
		rst(1'b1);
		chk("pending", 1, alarm_pending);
		chk("phase", 1, phase_flag);
		send(32'h64, 0, 1, 1);
		chk("sync", 0, sync_count);
		chk("elapsed", TIME_RST, elapsed_time);
		send(32'h64, 0, 1, 0);
		chk("sync", 1, sync_count);
		chk("elapsed", 32'h64, elapsed_time);
		chk("valid", 0, time_valid);
		// ticks with wave parameters present, still one sync short
		run = 1'b1;
		cyc(20);
		run = 1'b0;
		cyc(2);
		chk("wave", 0, wave_out);
		chk("elapsed", 32'h69, elapsed_time);
		chk("mono", 24'h5, mono_time);
		send(32'hc8, 1, 0, 0);
		chk("sync", 2, sync_count);
		chk("phase", 0, phase_flag);
		chk("pending", 0, alarm_pending);
		chk("valid", 1, time_valid);
		send(32'h12c, 0, 0, 0);
		chk("sync", 2, sync_count);
		chk("phase", 1, phase_flag);
		wr_alarm(32'h136);
		run = 1'b1;
		hunt(0);
		chk("alarm_time", 32'h136, elapsed_time);
		hunt(1);
		chk("pulse_mono", 24'h10, mono_time);
		hunt(3);
		chk("wave", 1, wave_out);
		hunt(4);
		run = 1'b0;
		chk("wave", 0, wave_out);
		phase_ref_in = 1'b1;
		cyc(40);
		chk("wave", 1, wave_out);
		phase_ref_in = 1'b0;
		rst(1'b0);
		chk("valid", 1, time_valid);
		chk("pending", 1, alarm_pending);
		run = 1'b1;
		hunt(1);
		chk("pulse", 0, pulse_out);
		chk("wave", 0, wave_out);
		pulse_par = {24'h000080, 24'h000001};
		pulse_par_wr = 1'b1;
		wr_alarm(32'ha0);
		pulse_par_wr = 1'b0;
		cyc(1);
		chk("pending", 0, alarm_pending);
		hunt(1);
		chk("pulse_mono", 24'h80, mono_time);
		hunt(2);
		hunt(1);
		chk("merge_mono", 24'h82, mono_time);
		hunt(0);
		chk("alarm_time", 32'ha0, elapsed_time);
		wave_par = 16'h0002;
		wave_par_wr = 1'b1;
		cyc(1);
		wave_par_wr = 1'b0;
		hunt(3);
		chk("wave", 1, wave_out);
		wrap_up();
	end
	initial begin
		#200us;
		bad_count++;
		wrap_up();
	end
endmodule

bind pfe_top pfe_monitor mon_u (.clk, .rstn, .master_mode, .alarm_wr, .alarm_time,
	.count_clk_in, .count_strobe_out, .elapsed_time, .time_valid, .alarm_pending,
	.alarm_out, .pulse_out, .phase_flag, .wave_out, .wave_bit, .sync_count);

// ---- src/pfe_edge.sv ----
// rising edge detector for a synchronous level input
`timescale 1ns/1ps
module pfe_edge (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic level,
	output logic      rise
);
	logic prev;
	logic next_prev;

	always_comb begin
		next_prev = level;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prev <= 1'b0;
		end else begin
			prev <= next_prev;
		end
	end

	assign rise = level & ~prev;
endmodule

// ---- src/pfe_pkg.sv ----
// constants and types shared by the post-reset facility enable block
// ----------------------------------------------------------------------------
// Contract
// - in message-driven modes, first valid message after reset gives first synchronisation
// - alarm, waveform and pulse outputs stay low until the second synchronisation
// - reset sets alarm pending; second synchronisation clears it and enables alarm
// - stand-alone: first alarm time write clears pending and enables the alarm
// - waveform generator starts once its first full parameter set is present
// - waveform output and its mirror bit frozen until second synchronisation
// - waveform parameters from early messages are still captured
// - reset stops waveform; stand-alone keeps it stopped until parameters arrive
// - phase flag is 1 after reset, takes first message pulse flag at second sync
// - phase pulses suppressed until second synchronisation; earliest pulse at T+2
// - pulse parameters from early messages are still captured
// - stand-alone: pulse generator disabled until first pulse parameters arrive
// - alarm fires in exactly the count cycle the counter meets alarm time
// - a pulse that would merge with the previous is delayed one count period
// - pulse times compare against the monotonous counter, not the main one
// - waveform realigns on each phase reference rising edge after about six crystal periods
// - first complete message loads the counter; partial message at reset ignored
// - time valid at once in stand-alone, else from the second synchronisation
// ----------------------------------------------------------------------------
package pfe_pkg;

	localparam int TIME_W = 32;
	localparam int MONO_W = 24;
	localparam int WAVE_W = 16;

	// ------------------------------------------------------------------------
	// reset values and unit increments
	// ------------------------------------------------------------------------
	localparam logic [TIME_W-1:0] TIME_RST      = {TIME_W{1'b1}};
	localparam logic [MONO_W-1:0] MONO_RST      = {MONO_W{1'b0}};
	localparam logic              PHASE_RST     = 1'b1;
	localparam logic              ALARM_PND_RST = 1'b1;
	localparam logic [TIME_W-1:0] TIME_ONE      = 32'h0000_0001;
	localparam logic [MONO_W-1:0] MONO_ONE      = 24'h00_0001;
	localparam logic [WAVE_W-1:0] WAVE_ONE      = 16'h0001;

	// ------------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 10;
	localparam int XTAL_PERIOD_NS = 60;
	localparam int REALIGN_XTALS  = 6;
	localparam int REALIGN_NS     = REALIGN_XTALS * XTAL_PERIOD_NS;
	localparam int REALIGN_CYC_I  = (REALIGN_NS / CLK_PERIOD_NS) < 1 ? 1 :
		(REALIGN_NS / CLK_PERIOD_NS);
	localparam logic [7:0] REALIGN_CYC = REALIGN_CYC_I[7:0];
	localparam logic [7:0] REALIGN_END = 8'h01;

	// ------------------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic [MONO_W-1:0] first;
		logic [MONO_W-1:0] period;
	} pfe_pulse_par_t;

	typedef struct packed {
		logic [WAVE_W-1:0] half;
	} pfe_wave_par_t;

	typedef struct packed {
		logic [TIME_W-1:0] elapsed;
		logic              pulse;
		logic              pulse_par_ok;
		pfe_pulse_par_t    pulse_par;
		logic              wave_par_ok;
		pfe_wave_par_t     wave_par;
	} pfe_msg_t;

	typedef enum logic [1:0] {
		SYNC_NONE,
		SYNC_ONE,
		SYNC_TWO
	} pfe_sync_t;

endpackage

// ---- src/pfe_sync_cnt.sv ----
// post-reset synchronisation counter, saturating at two
`timescale 1ns/1ps
module pfe_sync_cnt
	import pfe_pkg::*;
(
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic sync,
	output logic      first_sync,
	output logic      second_sync,
	output logic      synced2,
	output logic [1:0] count
);
	pfe_sync_t state;
	pfe_sync_t next_state;

	always_comb begin
		next_state = state;
		if (sync) begin
			unique case (state)
				SYNC_NONE: next_state = SYNC_ONE;
				SYNC_ONE:  next_state = SYNC_TWO;
				SYNC_TWO:  next_state = SYNC_TWO;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state <= SYNC_NONE;
		end else begin
			state <= next_state;
		end
	end

	assign first_sync  = sync & (state == SYNC_NONE);
	assign second_sync = sync & (state == SYNC_ONE);
	assign synced2     = (state == SYNC_TWO);
	assign count       = (state == SYNC_NONE) ? 2'h0 : (state == SYNC_ONE) ? 2'h1 : 2'h2;
endmodule

// ---- src/pfe_top.sv ----
// facility enable, counters, alarm, pulse and waveform generators after reset
`timescale 1ns/1ps
module pfe_top
	import pfe_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rstn,
	input  wire logic              master_mode,
	input  wire logic              msg_start,
	input  wire logic              msg_done,
	input  wire pfe_msg_t          msg,
	input  wire logic              alarm_wr,
	input  wire logic [TIME_W-1:0] alarm_time,
	input  wire logic              pulse_par_wr,
	input  wire pfe_pulse_par_t    pulse_par,
	input  wire logic              wave_par_wr,
	input  wire pfe_wave_par_t     wave_par,
	input  wire logic              count_clk_in,
	input  wire logic              phase_ref_in,
	output logic                   count_strobe_out,
	output logic [TIME_W-1:0]      elapsed_time,
	output logic [MONO_W-1:0]      mono_time,
	output logic                   time_valid,
	output logic                   alarm_pending,
	output logic                   alarm_out,
	output logic                   pulse_out,
	output logic                   phase_flag,
	output logic                   wave_out,
	output logic                   wave_bit,
	output logic [1:0]             sync_count
);

	// ------------------------------------------------------------------------
	// strobes and synchronisation count
	// ------------------------------------------------------------------------
	logic tick;
	logic phase_rise;
	logic msg_armed;
	logic msg_take;
	logic local_sync;
	logic first_sync;
	logic second_sync;
	logic synced2;

	pfe_edge u_tick_edge (
		.clk   (clk),
		.rstn  (rstn),
		.level (count_clk_in),
		.rise  (tick)
	);

	pfe_edge u_phase_edge (
		.clk   (clk),
		.rstn  (rstn),
		.level (phase_ref_in),
		.rise  (phase_rise)
	);

	// only a message whose start was seen after reset is complete
	assign msg_take   = msg_done & msg_armed;
	assign local_sync = msg_take & master_mode;

	pfe_sync_cnt u_sync_cnt (
		.clk         (clk),
		.rstn        (rstn),
		.sync        (local_sync),
		.first_sync  (first_sync),
		.second_sync (second_sync),
		.synced2     (synced2),
		.count       (sync_count)
	);

	// external counters share this strobe with the internal counter
	assign count_strobe_out = count_clk_in;

	// ------------------------------------------------------------------------
	// reception, counters, validity and phase flag
	// ------------------------------------------------------------------------
	logic              loaded_pulse;
	logic              next_msg_armed;
	logic              next_loaded_pulse;
	logic [TIME_W-1:0] next_elapsed;
	logic [MONO_W-1:0] next_mono;
	logic              next_time_valid;
	logic              next_phase;

	always_comb begin
		next_msg_armed    = msg_armed;
		next_loaded_pulse = loaded_pulse;
		next_elapsed      = elapsed_time;
		next_mono         = mono_time;
		next_time_valid   = time_valid;
		next_phase        = phase_flag;
		if (msg_done) begin
			next_msg_armed = 1'b0;
		end
		if (msg_start) begin
			next_msg_armed = 1'b1;
		end
		if (tick) begin
			next_elapsed = elapsed_time + TIME_ONE;
			next_mono = mono_time + MONO_ONE;
		end
		if (msg_take) begin
			next_elapsed = msg.elapsed;
		end
		if (local_sync) begin
			next_loaded_pulse = msg.pulse;
			if (!first_sync) begin
				next_phase = loaded_pulse;
			end
		end
		if (!master_mode) begin
			next_time_valid = 1'b1;
		end else if (second_sync) begin
			next_time_valid = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			msg_armed    <= 1'b0;
			loaded_pulse <= PHASE_RST;
			elapsed_time <= TIME_RST;
			mono_time    <= MONO_RST;
			time_valid   <= 1'b0;
			phase_flag   <= PHASE_RST;
		end else begin
			msg_armed    <= next_msg_armed;
			loaded_pulse <= next_loaded_pulse;
			elapsed_time <= next_elapsed;
			mono_time    <= next_mono;
			time_valid   <= next_time_valid;
			phase_flag   <= next_phase;
		end
	end

	// ------------------------------------------------------------------------
	// alarm clock
	// ------------------------------------------------------------------------
	logic [TIME_W-1:0] alarm_at;
	logic              alarm_set;
	logic              next_alarm_set;
	logic [TIME_W-1:0] next_alarm_at;
	logic              next_alarm_pending;
	logic              next_alarm_out;

	always_comb begin
		next_alarm_at      = alarm_at;
		next_alarm_set     = alarm_set;
		next_alarm_pending = alarm_pending;
		next_alarm_out     = 1'b0;
		if (alarm_wr) begin
			next_alarm_at  = alarm_time;
			next_alarm_set = 1'b1;
			if (!master_mode) begin
				next_alarm_pending = 1'b0;
			end
		end
		if (master_mode && second_sync) begin
			next_alarm_pending = 1'b0;
		end
		// output rises with the counter value that equals the alarm time
		if (alarm_set && !alarm_pending && tick && !msg_take
			&& (elapsed_time + TIME_ONE) == alarm_at) begin
			next_alarm_out = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			alarm_at      <= '0;
			alarm_set     <= 1'b0;
			alarm_pending <= ALARM_PND_RST;
			alarm_out     <= 1'b0;
		end else begin
			alarm_at      <= next_alarm_at;
			alarm_set     <= next_alarm_set;
			alarm_pending <= next_alarm_pending;
			alarm_out     <= next_alarm_out;
		end
	end

	// ------------------------------------------------------------------------
	// pulse generator
	// ------------------------------------------------------------------------
	logic [MONO_W-1:0] pp_next;
	logic [MONO_W-1:0] pp_period;
	logic              pp_have;
	logic              pp_defer;
	logic              pp_gate;
	logic              pp_due;
	logic [MONO_W-1:0] next_pp_next;
	logic [MONO_W-1:0] next_pp_period;
	logic              next_pp_have;
	logic              next_pp_defer;
	logic              next_pulse_out;

	assign pp_gate = master_mode ? (synced2 & pp_have) : pp_have;
	assign pp_due  = pp_have && tick && (mono_time + MONO_ONE) == pp_next;

	always_comb begin
		next_pp_next   = pp_next;
		next_pp_period = pp_period;
		next_pp_have   = pp_have;
		next_pp_defer  = pp_defer;
		next_pulse_out = pulse_out;
		if (tick) begin
			next_pulse_out = 1'b0;
			if (pp_due || pp_defer) begin
				if (!pp_gate) begin
					next_pp_defer = 1'b0;
				end else if (pulse_out) begin
					next_pp_defer = 1'b1;
				end else begin
					next_pulse_out = 1'b1;
					next_pp_defer  = 1'b0;
				end
			end
			if (pp_due) begin
				next_pp_next = pp_next + pp_period;
			end
		end
		if (msg_take && msg.pulse_par_ok) begin
			next_pp_next   = msg.pulse_par.first;
			next_pp_period = msg.pulse_par.period;
			next_pp_have   = 1'b1;
		end
		if (pulse_par_wr) begin
			next_pp_next   = pulse_par.first;
			next_pp_period = pulse_par.period;
			next_pp_have   = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pp_next   <= '0;
			pp_period <= '0;
			pp_have   <= 1'b0;
			pp_defer  <= 1'b0;
			pulse_out <= 1'b0;
		end else begin
			pp_next   <= next_pp_next;
			pp_period <= next_pp_period;
			pp_have   <= next_pp_have;
			pp_defer  <= next_pp_defer;
			pulse_out <= next_pulse_out;
		end
	end

	// ------------------------------------------------------------------------
	// waveform generator
	// ------------------------------------------------------------------------
	logic [WAVE_W-1:0] wv_half;
	logic              wv_have;
	logic [WAVE_W-1:0] wv_cnt;
	logic [7:0]        realign_cnt;
	logic              wv_run;
	logic [WAVE_W-1:0] next_wv_half;
	logic              next_wv_have;
	logic [WAVE_W-1:0] next_wv_cnt;
	logic [7:0]        next_realign_cnt;
	logic              next_wave;

	assign wv_run   = master_mode ? (synced2 & wv_have) : wv_have;
	assign wave_bit = wave_out;

	always_comb begin
		next_wv_half     = wv_half;
		next_wv_have     = wv_have;
		next_wv_cnt      = wv_cnt;
		next_realign_cnt = realign_cnt;
		next_wave        = wave_out;
		if (msg_take && msg.wave_par_ok) begin
			next_wv_half = msg.wave_par.half;
			next_wv_have = 1'b1;
		end
		if (wave_par_wr) begin
			next_wv_half = wave_par.half;
			next_wv_have = 1'b1;
		end
		if (!wv_run) begin
			next_wv_cnt      = '0;
			next_wave        = 1'b0;
			next_realign_cnt = '0;
		end else begin
			if (tick) begin
				if (wv_cnt + WAVE_ONE >= wv_half) begin
					next_wv_cnt = '0;
					next_wave   = ~wave_out;
				end else begin
					next_wv_cnt = wv_cnt + WAVE_ONE;
				end
			end
			if (realign_cnt != '0) begin
				next_realign_cnt = realign_cnt - REALIGN_END;
				if (realign_cnt == REALIGN_END) begin
					next_wv_cnt = '0;
					next_wave   = 1'b1;
				end
			end
			if (phase_rise) begin
				next_realign_cnt = REALIGN_CYC;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wv_half     <= '0;
			wv_have     <= 1'b0;
			wv_cnt      <= '0;
			realign_cnt <= '0;
			wave_out    <= 1'b0;
		end else begin
			wv_half     <= next_wv_half;
			wv_have     <= next_wv_have;
			wv_cnt      <= next_wv_cnt;
			realign_cnt <= next_realign_cnt;
			wave_out    <= next_wave;
		end
	end

endmodule
